// ---- rtl/fehx_pkg.sv ----
// constants and types for the frame, escape and halt execution block
package fehx_pkg;
  localparam logic [7:0]  OPC_FRAME      = 8'hc8;
  localparam logic [7:0]  OPC_ESC_LO     = 8'hd8;
  localparam logic [7:0]  OPC_ESC_HI     = 8'hdf;
  localparam logic [7:0]  OPC_HALT       = 8'hf4;
  localparam logic [7:0]  ESC_TRAP_VEC   = 8'h07;
  localparam logic [4:0]  LEVEL_MASK     = 5'h1f;
  localparam logic [15:0] PTR_STEP       = 16'h0002;
  // clock figures of the frame and halt operations and of the wake from reset, then reset values
  localparam int          FRAME_L0_W16   = 15;
  localparam int          FRAME_L1_W16   = 25;
  localparam int          FRAME_L0_W8    = 19;
  localparam int          FRAME_L1_W8    = 29;
  localparam int          FRAME_STEP_W16 = 16;
  localparam int          FRAME_STEP_W8  = 20;
  localparam int          HALT_CLOCKS    = 2;
  localparam int          RESET_WAKE     = 4;
  localparam logic [15:0] SP_RESET       = 16'h0000;
  localparam logic [15:0] BP_RESET       = 16'h0000;
  localparam logic [15:0] IP_RESET       = 16'h0000;
  localparam logic [15:0] CS_RESET       = 16'hffff;
  typedef enum logic [2:0] {
    FEHX_DORMANT, FEHX_IDLE, FEHX_FRAME, FEHX_TRAP, FEHX_HALT_ENTER,
    FEHX_HALTED, FEHX_VECTOR
  } fehx_state_t;
endpackage

// ---- rtl/fehx_cycle_timer.sv ----
// loadable cycle counter that spaces out instruction completion
`timescale 1ns/1ps
module fehx_cycle_timer (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // control
  input  wire logic        load,
  input  wire logic [9:0]  count,
  // status
  output logic             busy
);
  typedef struct packed {
    logic [9:0] cnt;
  } fehx_tmr_t;
  fehx_tmr_t s_q;
  fehx_tmr_t s_d;
  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.cnt = count;
    end else if (s_q.cnt != 10'h000) begin
      s_d.cnt = s_q.cnt - 10'h001;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign busy = (s_q.cnt > 10'h001);
endmodule // fehx_cycle_timer

// ---- rtl/fehx_wake_sync.sv ----
// two-stage synchroniser for the request pins
`timescale 1ns/1ps
module fehx_wake_sync (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // raw and synchronised levels
  input  wire logic [1:0]  raw_in,
  output logic [1:0]       sync_out
);
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
  } fehx_sync_t;
  fehx_sync_t s_q;
  fehx_sync_t s_d;
  always_comb begin
    s_d      = s_q;
    s_d.meta = raw_in;
    s_d.sync = s_q.meta;
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign sync_out = s_q.sync;
endmodule // fehx_wake_sync

// ---- rtl/fehx_exec.sv ----
// execution of the frame creation, escape trap and halt instructions
`timescale 1ns/1ps
module fehx_exec (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // configuration
  input  wire logic        bus_is_8bit,
  // instruction issue
  input  wire logic        issue_valid,
  output logic             issue_ready,
  input  wire logic [7:0]  issue_opcode,
  input  wire logic [15:0] issue_imm16,
  input  wire logic [7:0]  issue_imm8,
  input  wire logic [15:0] issue_next_ip,
  input  wire logic [15:0] issue_cs,
  // architectural state in and out
  input  wire logic [15:0] arch_flags_in,
  output logic [15:0]      arch_flags,
  output logic [15:0]      frame_base_pointer,
  output logic [15:0]      stack_top_pointer,
  output logic [15:0]      instruction_pointer,
  output logic [15:0]      code_segment,
  // stack write port
  output logic             stk_wr_en,
  output logic [15:0]      stk_wr_addr,
  output logic [15:0]      stk_wr_data,
  // interrupt requests
  input  wire logic        intr_enable,
  input  wire logic        ext_maskable_req,
  input  wire logic        ext_nmi_req,
  input  wire logic        periph_maskable_req,
  // vectoring and status
  output logic             vector_take,
  output logic [7:0]       vector_num,
  output logic             halted,
  output logic             fetch_enable,
  output logic             op_done
);
  typedef struct packed {
    fehx_pkg::fehx_state_t st;
    logic [15:0]           bp;
    logic [15:0]           sp;
    logic [15:0]           fp;
    logic [15:0]           bytes;
    logic [4:0]            level;
    logic [4:0]            idx;
    logic                  fp_pushed;
    logic [15:0]           ip;
    logic [15:0]           cs;
    logic [15:0]           flags;
    logic                  wr_en;
    logic [15:0]           wr_addr;
    logic [15:0]           wr_data;
    logic                  vtake;
    logic [7:0]            vnum;
    logic                  done;
    logic [3:0]            wake_cnt;
  } fehx_exec_s_t;

  fehx_exec_s_t s_q;
  fehx_exec_s_t s_d;
  logic [1:0]   req_sync;
  logic         tmr_load;
  logic [9:0]   tmr_count;
  logic         tmr_busy;
  logic         wake_req;

  function automatic logic is_escape(input logic [7:0] op);
    is_escape = (op >= fehx_pkg::OPC_ESC_LO) && (op <= fehx_pkg::OPC_ESC_HI);
  endfunction

  function automatic logic [9:0] frame_clocks(input logic [4:0] lvl, input logic b8);
    int n;
    n = 0;
    if (lvl == 5'h00) begin
      n = b8 ? fehx_pkg::FRAME_L0_W8 : fehx_pkg::FRAME_L0_W16;
    end else begin
      n = b8 ? fehx_pkg::FRAME_L1_W8 + fehx_pkg::FRAME_STEP_W8 * (int'(lvl) - 1)
             : fehx_pkg::FRAME_L1_W16 + fehx_pkg::FRAME_STEP_W16 * (int'(lvl) - 1);
    end
    frame_clocks = n[9:0];
  endfunction

  fehx_wake_sync u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .raw_in   ({ext_nmi_req, ext_maskable_req}),
    .sync_out (req_sync)
  );

  fehx_cycle_timer u_timer (
    .core_clk (core_clk),
    .srst     (srst),
    .load     (tmr_load),
    .count    (tmr_count),
    .busy     (tmr_busy)
  );

  // peripherals run on core_clk, so their request needs no synchroniser
  assign wake_req = req_sync[1] || (intr_enable && (req_sync[0] || periph_maskable_req));

  always_comb begin
    s_d       = s_q;
    s_d.wr_en = 1'b0;
    s_d.vtake = 1'b0;
    s_d.done  = 1'b0;
    tmr_load  = 1'b0;
    tmr_count = 10'h000;
    case (s_q.st)
      fehx_pkg::FEHX_DORMANT: begin
        if (s_q.wake_cnt == 4'(fehx_pkg::RESET_WAKE)) begin
          s_d.st = fehx_pkg::FEHX_IDLE;
        end else begin
          s_d.wake_cnt = s_q.wake_cnt + 4'h1;
        end
      end
      fehx_pkg::FEHX_IDLE: begin
        s_d.flags = arch_flags_in;
        if (issue_valid) begin
          s_d.ip = issue_next_ip;
          s_d.cs = issue_cs;
          if (issue_opcode == fehx_pkg::OPC_FRAME) begin
            s_d.bytes     = issue_imm16;
            s_d.level     = issue_imm8[4:0] & fehx_pkg::LEVEL_MASK;
            s_d.idx       = 5'h01;
            s_d.fp_pushed = 1'b0;
            s_d.sp        = s_q.sp - fehx_pkg::PTR_STEP;
            s_d.fp        = s_q.sp - fehx_pkg::PTR_STEP;
            s_d.wr_en     = 1'b1;
            s_d.wr_addr   = s_q.sp - fehx_pkg::PTR_STEP;
            s_d.wr_data   = s_q.bp;
            tmr_load      = 1'b1;
            tmr_count     = frame_clocks(issue_imm8[4:0], bus_is_8bit);
            s_d.st        = fehx_pkg::FEHX_FRAME;
          end else if (is_escape(issue_opcode)) begin
            s_d.st = fehx_pkg::FEHX_TRAP;
          end else if (issue_opcode == fehx_pkg::OPC_HALT) begin
            tmr_load  = 1'b1;
            tmr_count = 10'(fehx_pkg::HALT_CLOCKS);
            s_d.st    = fehx_pkg::FEHX_HALT_ENTER;
          end
        end
      end
      fehx_pkg::FEHX_FRAME: begin
        if (s_q.level != 5'h00 && s_q.idx < s_q.level) begin
          s_d.bp      = s_q.bp - fehx_pkg::PTR_STEP;
          s_d.sp      = s_q.sp - fehx_pkg::PTR_STEP;
          s_d.wr_en   = 1'b1;
          s_d.wr_addr = s_q.sp - fehx_pkg::PTR_STEP;
          s_d.wr_data = s_q.bp - fehx_pkg::PTR_STEP;
          s_d.idx     = s_q.idx + 5'h01;
        end else if (s_q.level != 5'h00 && !s_q.fp_pushed) begin
          s_d.sp        = s_q.sp - fehx_pkg::PTR_STEP;
          s_d.wr_en     = 1'b1;
          s_d.wr_addr   = s_q.sp - fehx_pkg::PTR_STEP;
          s_d.wr_data   = s_q.fp;
          s_d.fp_pushed = 1'b1;
        end else if (!tmr_busy) begin
          s_d.bp   = s_q.fp;
          s_d.sp   = s_q.sp - s_q.bytes;
          s_d.done = 1'b1;
          s_d.st   = fehx_pkg::FEHX_IDLE;
        end
      end
      fehx_pkg::FEHX_TRAP: begin
        s_d.vtake = 1'b1;
        s_d.vnum  = fehx_pkg::ESC_TRAP_VEC;
        s_d.done  = 1'b1;
        s_d.st    = fehx_pkg::FEHX_IDLE;
      end
      fehx_pkg::FEHX_HALT_ENTER: begin
        if (!tmr_busy) begin
          s_d.done = 1'b1;
          s_d.st   = fehx_pkg::FEHX_HALTED;
        end
      end
      fehx_pkg::FEHX_HALTED: begin
        if (wake_req) begin
          s_d.st = fehx_pkg::FEHX_VECTOR;
        end
      end
      fehx_pkg::FEHX_VECTOR: begin
        s_d.vtake = 1'b1;
        s_d.vnum  = 8'h00;
        s_d.st    = fehx_pkg::FEHX_IDLE;
      end
      default: begin
        s_d.st = fehx_pkg::FEHX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q          <= '0;
      s_q.st       <= fehx_pkg::FEHX_DORMANT;
      s_q.bp       <= fehx_pkg::BP_RESET;
      s_q.sp       <= fehx_pkg::SP_RESET;
      s_q.ip       <= fehx_pkg::IP_RESET;
      s_q.cs       <= fehx_pkg::CS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign issue_ready         = (s_q.st == fehx_pkg::FEHX_IDLE);
  assign arch_flags          = s_q.flags;
  assign frame_base_pointer  = s_q.bp;
  assign stack_top_pointer   = s_q.sp;
  assign instruction_pointer = s_q.ip;
  assign code_segment        = s_q.cs;
  assign stk_wr_en           = s_q.wr_en;
  assign stk_wr_addr         = s_q.wr_addr;
  assign stk_wr_data         = s_q.wr_data;
  assign vector_take         = s_q.vtake;
  assign vector_num          = s_q.vnum;
  assign halted              = (s_q.st == fehx_pkg::FEHX_HALTED);
  assign fetch_enable        = (s_q.st != fehx_pkg::FEHX_DORMANT) &&
                               (s_q.st != fehx_pkg::FEHX_HALTED);
  assign op_done             = s_q.done;
endmodule // fehx_exec

// ---- tb/fehx_exec_assertions.sv ----
// assertion checker for the frame, escape and halt execution block
`timescale 1ns/1ps
module fehx_exec_assertions (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // issue and status
  input wire logic        issue_valid,
  input wire logic        issue_ready,
  input wire logic [7:0]  issue_opcode,
  input wire logic        ext_nmi_req,
  input wire logic        vector_take,
  input wire logic [7:0]  vector_num,
  input wire logic        halted,
  input wire logic        fetch_enable,
  input wire logic        op_done,
  // state and stack
  input wire logic [15:0] arch_flags,
  input wire logic [15:0] stack_top_pointer,
  input wire logic [15:0] code_segment,
  input wire logic        stk_wr_en,
  input wire logic [15:0] stk_wr_addr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_esc;
    issue_valid && issue_ready && issue_opcode[7:3] == 5'h1b;
  endsequence
  sequence s_halt;
    issue_valid && issue_ready && issue_opcode == fehx_pkg::OPC_HALT;
  endsequence
  sequence s_sleep;
    op_done ##1 halted && !fetch_enable;
  endsequence
  property p_esc;
    s_esc |-> ##2 vector_take && vector_num == fehx_pkg::ESC_TRAP_VEC;
  endproperty
  a_esc: assert property (p_esc) else $error("escape trap missing");
  property p_halt;
    s_halt |-> ##3 s_sleep;
  endproperty
  a_halt: assert property (p_halt) else $error("halt timing wrong");
  property p_hold;
    halted |-> !issue_ready && !fetch_enable;
  endproperty
  a_hold: assert property (p_hold) else $error("work while halted");
  property p_push;
    stk_wr_en |-> stk_wr_addr == stack_top_pointer;
  endproperty
  a_push: assert property (p_push) else $error("push address wrong");
  property p_flags;
    !issue_ready ##1 !issue_ready |-> $stable(arch_flags);
  endproperty
  a_flags: assert property (p_flags) else $error("flags changed");
  property p_rst;
    disable iff (1'b0) srst |=> stack_top_pointer == 16'h0000 &&
      code_segment == fehx_pkg::CS_RESET && !fetch_enable;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_wake;
    $fell(srst) |-> !issue_ready [*4] ##[1:4] issue_ready;
  endproperty
  a_wake: assert property (p_wake) else $error("dormant span wrong");
  property p_nmi;
    halted && ext_nmi_req |-> ##[1:6] vector_take;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi did not wake");
endmodule // fehx_exec_assertions

bind fehx_exec fehx_exec_assertions fehx_exec_assertions_inst (
  .core_clk, .srst, .issue_valid, .issue_ready, .issue_opcode, .ext_nmi_req,
  .vector_take, .vector_num, .halted, .fetch_enable, .op_done, .arch_flags,
  .stack_top_pointer, .code_segment, .stk_wr_en, .stk_wr_addr
);

// ---- tb/fehx_req_model.sv ----
// external and peripheral interrupt request sources
`timescale 1ns/1ps
module fehx_req_model (
  // clock
  input wire logic       core_clk,
  // request choice from the bench
  input wire logic [2:0] req_sel,
  // request pins
  output logic           ext_maskable_req,
  output logic           ext_nmi_req,
  output logic           periph_maskable_req
);
  initial begin
    {ext_maskable_req, ext_nmi_req, periph_maskable_req} = 3'h0;
  end
  // pins are asynchronous, so they move well away from the edge
  always @(posedge core_clk) begin
    #7;
    ext_maskable_req = req_sel[0];
    ext_nmi_req = req_sel[1];
  end
  // peripherals keep running and request on the core clock
  always @(posedge core_clk) begin
    periph_maskable_req <= req_sel[2];
  end
endmodule // fehx_req_model

// ---- tb/fehx_exec_tb.sv ----
// self-checking bench for the frame, escape and halt execution block
`timescale 1ns/1ps
module fehx_exec_tb;
  logic core_clk, srst, bus_is_8bit, issue_valid, intr_enable;
  logic issue_ready, stk_wr_en, vector_take, halted, fetch_enable, op_done;
  logic ext_maskable_req, ext_nmi_req, periph_maskable_req;
  logic [2:0] req_sel;
  logic [7:0] issue_opcode, issue_imm8, vector_num, lv[5];
  logic [15:0] issue_imm16, issue_next_ip, issue_cs, arch_flags_in, arch_flags;
  logic [15:0] frame_base_pointer, stack_top_pointer, instruction_pointer;
  logic [15:0] code_segment, stk_wr_addr, stk_wr_data, esp, ebp, eip, ecs, f;
  int fails, compares, cyc;
  fehx_exec fehx_exec_inst (.core_clk, .srst, .bus_is_8bit, .issue_valid,
    .issue_ready, .issue_opcode, .issue_imm16, .issue_imm8, .issue_next_ip,
    .issue_cs, .arch_flags_in, .arch_flags, .frame_base_pointer,
    .stack_top_pointer, .instruction_pointer, .code_segment, .stk_wr_en,
    .stk_wr_addr, .stk_wr_data, .intr_enable, .ext_maskable_req, .ext_nmi_req,
    .periph_maskable_req, .vector_take, .vector_num, .halted, .fetch_enable,
    .op_done);
  fehx_req_model fehx_req_model_inst (.core_clk, .req_sel, .ext_maskable_req,
    .ext_nmi_req, .periph_maskable_req);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  function automatic int clocks(input int l, input logic b);
    if (l == 0) return b ? fehx_pkg::FRAME_L0_W8 : fehx_pkg::FRAME_L0_W16;
    if (b) return fehx_pkg::FRAME_L1_W8 + (l - 1) * fehx_pkg::FRAME_STEP_W8;
    return fehx_pkg::FRAME_L1_W16 + (l - 1) * fehx_pkg::FRAME_STEP_W16;
  endfunction
  task automatic issue(input logic [7:0] op, input logic [15:0] nb, input logic [7:0] l);
    int w;
    w = 0;
    {issue_opcode, issue_imm16, issue_imm8} = {op, nb, l};
    eip = 16'($urandom);
    ecs = 16'($urandom);
    {issue_next_ip, issue_cs, issue_valid} = {eip, ecs, 1'b1};
    while (issue_ready !== 1'b1 && w < 100) begin
      step(1);
      w++;
    end
    step(1);
    issue_valid = 1'b0;
  endtask
  task automatic frame(input logic [7:0] lvl, input logic [15:0] nb);
    int l;
    logic [15:0] q[$];
    logic [15:0] fp;
    l = lvl % 32;
    fp = esp - 16'h0002;
    q.push_back(ebp);
    for (int i = 1; i < l; i++) q.push_back(ebp - 16'(2 * i));
    if (l > 0) q.push_back(fp);
    issue(fehx_pkg::OPC_FRAME, nb, lvl);
    cyc = 0;
    while (op_done !== 1'b1 && cyc < 1200) begin
      if (stk_wr_en === 1'b1 && q.size() > 0) begin
        esp = esp - 16'h0002;
        chk(stk_wr_addr, esp);
        chk(stk_wr_data, q.pop_front());
      end
      step(1);
      cyc++;
    end
    chk(16'(q.size()), 16'h0000);
    chk(16'(cyc), 16'(clocks(l, bus_is_8bit)));
    chk(frame_base_pointer, fp);
    esp = esp - nb;
    ebp = fp;
    chk(stack_top_pointer, esp);
  endtask
  initial begin
    void'($urandom(32'hbc7af5db));
    {srst, bus_is_8bit, issue_valid, intr_enable, req_sel} = 7'h40;
    {issue_opcode, issue_imm8, issue_imm16, issue_next_ip} = 48'h0;
    {issue_cs, arch_flags_in, esp, ebp} = 64'h0;
    lv = '{8'h00, 8'h01, 8'h02, 8'h1f, 8'h20};
    step(16);
    chk(stack_top_pointer, 16'h0000);
    chk(code_segment, fehx_pkg::CS_RESET);
    srst = 1'b0;
    for (int b = 0; b < 2; b++) begin
      bus_is_8bit = b[0];
      foreach (lv[i]) frame(lv[i], 16'($urandom));
      repeat (3) frame(8'($urandom), 16'($urandom));
    end
    $display("frame test done");
    for (int k = 0; k < 8; k++) begin
      f = 16'($urandom);
      arch_flags_in = f;
      issue(fehx_pkg::OPC_ESC_LO + 8'(k), 16'($urandom), 8'($urandom));
      arch_flags_in = ~f;
      step(1);
      chk(16'(vector_take), 16'h0001);
      chk(16'(vector_num), 16'(fehx_pkg::ESC_TRAP_VEC));
      chk(arch_flags, f);
    end
    $display("escape test done");
    for (int k = 0; k < 3; k++) begin
      intr_enable = 1'b0;
      issue(fehx_pkg::OPC_HALT, 16'h0000, 8'h00);
      step(2);
      chk(16'(op_done), 16'h0001);
      step(1);
      chk(16'({halted, fetch_enable}), 16'h0002);
      chk(instruction_pointer, eip);
      chk(code_segment, ecs);
      req_sel = 3'h5;
      step(8);
      chk(16'(halted), 16'h0001);
      intr_enable = k != 1;
      req_sel = 3'h1 << k;
      cyc = 0;
      while (vector_take !== 1'b1 && cyc < 20) begin
        step(1);
        cyc++;
      end
      chk(16'(vector_take), 16'h0001);
      chk(instruction_pointer, eip);
      req_sel = 3'h0;
    end
    $display("halt test done");
    issue(fehx_pkg::OPC_FRAME, 16'h0010, 8'h1f);
    step(5);
    srst = 1'b1;
    step(1);
    chk(stack_top_pointer, 16'h0000);
    srst = 1'b0;
    step(1);
    chk(16'(fetch_enable), 16'h0000);
    {esp, ebp} = 32'h0;
    frame(8'h01, 16'h0004);
    $display("reset test done");
    finish_test();
  end
  initial begin
    #2000000;
    fails++;
    finish_test();
  end
endmodule // fehx_exec_tb
